// ---- src/oscillator_control_lock.sv ----
// Oscillator control register with two-byte unlock, oscillator gating,
// failure detection and system clock source selection.
// Assumes software on clk_in; oscillator-good inputs come from other domains.
//
// Overview of operation
// - Register accepts a write only after E7 then 18 written to it.
// - After a successful write the register locks again.
// - Bit 7 runs or stops the internal precision oscillator.
// - Bit 6 enables crystal oscillator, overriding GPIO control of two pins.
// - Bit 5 runs or stops the watchdog timer oscillator.
// - Bit 4 enables failure detection and recovery of the system clock source.
// - Low three-bit field selects the oscillator driving the system clock.
// - No detection and no working source stops the device until power-on reset.
// - Watchdog oscillator failure time is counted in system clocks.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module oscillator_control_lock (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [11:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic int_osc_good_in,
   input wire logic xtal_osc_good_in,
   input wire logic wdt_osc_tick_in,
   output logic internal_osc_enable_out,
   output logic crystal_osc_enable_out,
   output logic watchdog_osc_enable_out,
   output logic port_a_pin_zero_xtal_out,
   output logic port_a_pin_one_xtal_out,
   output logic [osc_ctl_pkg::SEL_W-1:0] sysclk_source_out,
   output logic sysclk_fail_out,
   output logic watchdog_osc_fail_out,
   output logic device_halt_out
);
   import osc_ctl_pkg::*;

   logic [7:0] ctl_q;
   lock_state_t lock_q;
   logic hit;
   logic reg_wr;
   logic [2:0] int_s_q, xtl_s_q, wdt_s_q;
   logic wdt_prev_q;
   logic [FAIL_CNT_W-1:0] wdt_cnt_q;
   logic wdt_fail_q, sys_fail_q, halt_q;
   logic [7:0] rdata_q;
   logic src_good;

   assign hit = addr_in == OSC_CTL_ADDR;
   assign reg_wr = wr_in && hit && lock_q == LK_OPEN;

   // ----------------------------------------------------------------
   // Unlock sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         lock_q <= LK_LOCKED;
      end else if (wr_in && hit) begin
         case (lock_q)
            LK_LOCKED: lock_q <= (wdata_in == UNLOCK_FIRST) ? LK_HALF : LK_LOCKED;
            LK_HALF: lock_q <= (wdata_in == UNLOCK_SECOND) ? LK_OPEN : LK_LOCKED;
            LK_OPEN: lock_q <= LK_LOCKED;
            default: lock_q <= LK_LOCKED;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctl_q <= OSC_CTL_RESET;
      end else if (reg_wr) begin
         ctl_q <= wdata_in;
      end else if (sys_fail_q && ctl_q[SYS_FD_BIT] && ctl_q[SEL_W-1:0] != SRC_INTERNAL) begin
         // Recovery: fall back to the internal oscillator
         ctl_q[INT_EN_BIT] <= 1'b1;
         ctl_q[SEL_W-1:0] <= SRC_INTERNAL;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= (rd_in && hit) ? ctl_q : 8'h00;
      end
   end
   assign rdata_out = rdata_q;

   assign internal_osc_enable_out = ctl_q[INT_EN_BIT];
   assign crystal_osc_enable_out = ctl_q[XTL_EN_BIT];
   assign port_a_pin_zero_xtal_out = ctl_q[XTL_EN_BIT];
   assign port_a_pin_one_xtal_out = ctl_q[XTL_EN_BIT];
   assign watchdog_osc_enable_out = ctl_q[WDT_EN_BIT];
   assign sysclk_source_out = ctl_q[SEL_LSB +: SEL_W];

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         // Internal oscillator assumed running out of reset; avoids a false stop
         int_s_q <= 3'h7;
         xtl_s_q <= 3'h0;
         wdt_s_q <= 3'h0;
         wdt_prev_q <= 1'b0;
      end else begin
         int_s_q <= {int_s_q[1:0], int_osc_good_in};
         xtl_s_q <= {xtl_s_q[1:0], xtal_osc_good_in};
         wdt_s_q <= {wdt_s_q[1:0], wdt_osc_tick_in};
         if (wdt_s_q[2] == wdt_s_q[1]) begin
            wdt_prev_q <= wdt_s_q[2];
         end
      end
   end

   // ----------------------------------------------------------------
   // Failure detection
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wdt_cnt_q <= '0;
         wdt_fail_q <= 1'b0;
      end else if (!ctl_q[WDT_FD_BIT] || !ctl_q[WDT_EN_BIT]) begin
         wdt_cnt_q <= '0;
         wdt_fail_q <= 1'b0;
      end else if (wdt_s_q[2] == wdt_s_q[1] && wdt_s_q[2] != wdt_prev_q) begin
         wdt_cnt_q <= '0;
         wdt_fail_q <= 1'b0;
      end else if (wdt_cnt_q == FAIL_CNT_W'(WDT_FAIL_CYCLES - 1)) begin
         wdt_fail_q <= 1'b1;
      end else begin
         wdt_cnt_q <= wdt_cnt_q + 1'b1;
      end
   end

   always_comb begin
      case (ctl_q[SEL_W-1:0])
         SRC_INTERNAL: src_good = ctl_q[INT_EN_BIT] && int_s_q[2] && int_s_q[1];
         SRC_CRYSTAL: src_good = ctl_q[XTL_EN_BIT] && xtl_s_q[2] && xtl_s_q[1];
         SRC_WATCHDOG: src_good = ctl_q[WDT_EN_BIT] && !wdt_fail_q;
         default: src_good = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sys_fail_q <= 1'b0;
      end else begin
         sys_fail_q <= ctl_q[SYS_FD_BIT] && !src_good;
      end
   end

   // Sticky stop: only reset brings the device back
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         halt_q <= 1'b0;
      end else if (!ctl_q[SYS_FD_BIT] && !src_good) begin
         halt_q <= 1'b1;
      end
   end

   assign sysclk_fail_out = sys_fail_q;
   assign watchdog_osc_fail_out = wdt_fail_q;
   assign device_halt_out = halt_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_locked_no_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wr_in && hit && lock_q != LK_OPEN && !(sys_fail_q && ctl_q[SYS_FD_BIT]))
      |=> ctl_q == $past(ctl_q)) else $error("write landed while locked");
   a_relock_after_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      reg_wr |=> lock_q == LK_LOCKED && ctl_q == $past(wdata_in))
      else $error("no relock or bad store");
   a_bad_second_byte: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (wr_in && hit && lock_q == LK_HALF && wdata_in != UNLOCK_SECOND)
      |=> lock_q == LK_LOCKED) else $error("bad key opened lock");
   a_int_osc_enable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      reg_wr |=> internal_osc_enable_out == $past(wdata_in[INT_EN_BIT]))
      else $error("internal enable wrong");
   a_xtal_pin_override: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      reg_wr |=> crystal_osc_enable_out == $past(wdata_in[XTL_EN_BIT])
      && port_a_pin_zero_xtal_out == crystal_osc_enable_out
      && port_a_pin_one_xtal_out == crystal_osc_enable_out)
      else $error("crystal pins not claimed");
   a_wdt_osc_enable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      reg_wr |=> watchdog_osc_enable_out == $past(wdata_in[WDT_EN_BIT]))
      else $error("watchdog enable wrong");
   a_sys_fail_gated: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      sys_fail_q |-> $past(ctl_q[SYS_FD_BIT])) else $error("fail without detect");
   a_source_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      reg_wr |=> sysclk_source_out == $past(wdata_in[2:0])) else $error("select lost");
   a_halt_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      halt_q |=> halt_q) else $error("halt released without reset");
   a_wdt_fail_time: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(wdt_fail_q) |-> $past(ctl_q[WDT_FD_BIT])
      && wdt_cnt_q == FAIL_CNT_W'(WDT_FAIL_CYCLES - 1))
      else $error("watchdog fail timing wrong");
   a_wdt_detect_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !ctl_q[WDT_FD_BIT] |=> !wdt_fail_q) else $error("watchdog detect not gated");
endmodule : oscillator_control_lock
`default_nettype wire

// ---- src/osc_ctl_pkg.sv ----
// Package for the oscillator control block: register offset, fields, reset value,
// unlock codes and failure-detection timing.
// Assumes an 8-bit register port on a 12-bit register-file address.
package osc_ctl_pkg;
   localparam logic [11:0] OSC_CTL_ADDR = 12'hF86;
   localparam logic [7:0] OSC_CTL_RESET = 8'hA0;
   localparam logic [7:0] UNLOCK_FIRST = 8'hE7;
   localparam logic [7:0] UNLOCK_SECOND = 8'h18;
   localparam int INT_EN_BIT = 7;
   localparam int XTL_EN_BIT = 6;
   localparam int WDT_EN_BIT = 5;
   localparam int SYS_FD_BIT = 4;
   localparam int WDT_FD_BIT = 3;
   localparam int SEL_LSB = 0;
   localparam int SEL_W = 3;
   // Source-select codes
   localparam logic [2:0] SRC_INTERNAL = 3'h0;
   localparam logic [2:0] SRC_CRYSTAL = 3'h1;
   localparam logic [2:0] SRC_WATCHDOG = 3'h3;
   // Watchdog oscillator failure window, counted in system clocks
   localparam int WDT_FAIL_CYCLES = 64;
   localparam int FAIL_CNT_W = 8;
   typedef enum logic [1:0] {LK_LOCKED, LK_HALF, LK_OPEN} lock_state_t;
endpackage : osc_ctl_pkg

// ---- dv/oscillator_control_lock_bench.sv ----
// Self-checking bench for the oscillator control register block.
// Assumes the design's own assertions run alongside; no partner model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module oscillator_control_lock_bench;
   import osc_ctl_pkg::*;
   logic clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0;
   logic [11:0] addr_in = OSC_CTL_ADDR;
   logic [7:0] wdata_in = 8'h00, rdata_out;
   logic int_good = 1, xtal_good = 1, tick = 0, tick_run = 1;
   logic int_en, xtal_en, wdt_en, pa0, pa1, sys_fail, wdt_fail, halt;
   logic [2:0] src;
   logic [1:0] tick_div = 2'h0;
   int fails = 0, n_checks = 0, n;
   typedef struct {logic [7:0] val; logic [5:0] exp;} row_t;
   row_t rows[4] = '{'{8'hC1, 6'h31}, '{8'h80, 6'h20},
      '{8'hEB, 6'h3B}, '{8'hB8, 6'h28}};
   always #50 clk_in = ~clk_in;
   // Watchdog tick slow enough for the input filter to see each level
   always @(posedge clk_in) begin
      if (tick_run) begin
         tick_div <= tick_div + 2'h1;
         if (tick_div == 2'h3) tick <= ~tick;
      end
   end
   oscillator_control_lock u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .int_osc_good_in(int_good), .xtal_osc_good_in(xtal_good), .wdt_osc_tick_in(tick),
      .internal_osc_enable_out(int_en), .crystal_osc_enable_out(xtal_en),
      .watchdog_osc_enable_out(wdt_en), .port_a_pin_zero_xtal_out(pa0),
      .port_a_pin_one_xtal_out(pa1), .sysclk_source_out(src), .sysclk_fail_out(sys_fail),
      .watchdog_osc_fail_out(wdt_fail), .device_halt_out(halt));
   // ------------------------------
   // Bus tasks
   // ------------------------------
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
      @(posedge clk_in); wr_in <= 1'b0;
      @(posedge clk_in);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      addr_in <= a; rd_in <= 1'b1;
      @(posedge clk_in); rd_in <= 1'b0;
      #1 `CHK("rdata", e, rdata_out)
      @(posedge clk_in);
   endtask : rd
   task automatic unlocked_wr(input logic [7:0] d);
      wr(OSC_CTL_ADDR, UNLOCK_FIRST); wr(OSC_CTL_ADDR, UNLOCK_SECOND); wr(OSC_CTL_ADDR, d);
   endtask : unlocked_wr
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(OSC_CTL_ADDR, OSC_CTL_RESET);
      rd(12'hF87, 8'h00);
      wr(OSC_CTL_ADDR, 8'h81); rd(OSC_CTL_ADDR, OSC_CTL_RESET);
      foreach (rows[i]) begin
         unlocked_wr(rows[i].val);
         #1 `CHK("enables", rows[i].exp[5:3], {int_en, xtal_en, wdt_en})
         `CHK("pins", {2{rows[i].exp[4]}}, {pa0, pa1})
         `CHK("source", rows[i].exp[2:0], src)
         rd(OSC_CTL_ADDR, rows[i].val);
         wr(OSC_CTL_ADDR, 8'hC1); rd(OSC_CTL_ADDR, rows[i].val);
      end
      wr(OSC_CTL_ADDR, UNLOCK_FIRST); wr(OSC_CTL_ADDR, 8'h55); wr(OSC_CTL_ADDR, 8'hC1);
      rd(OSC_CTL_ADDR, 8'hB8);
      tick_run <= 1'b0;
      for (n = 0; n < 100 && wdt_fail !== 1'b1; n++) @(posedge clk_in) #1;
      `CHK("wdt_fail_time", 1'b1, n >= WDT_FAIL_CYCLES && n <= WDT_FAIL_CYCLES + 8)
      unlocked_wr(8'hB0); #1 `CHK("wdt_fail_off", 1'b0, wdt_fail)
      tick_run <= 1'b1;
      unlocked_wr(8'hD1);
      xtal_good <= 1'b0;
      for (n = 0; n < 20 && src !== SRC_INTERNAL; n++) @(posedge clk_in) #1;
      `CHK("recovery", 1'b1, n < 20)
      rd(OSC_CTL_ADDR, 8'hD0);
      `CHK("no_halt", 1'b0, halt)
      unlocked_wr(8'h81);
      for (n = 0; n < 20 && halt !== 1'b1; n++) @(posedge clk_in) #1;
      `CHK("halt", 1'b1, halt)
      xtal_good <= 1'b1;
      repeat (5) @(posedge clk_in);
      #1 `CHK("halt_sticky", 1'b1, halt)
      rst_n_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      #1 `CHK("halt_reset", 1'b0, halt)
      rd(OSC_CTL_ADDR, OSC_CTL_RESET);
      `CHK("halt_after_reset", 1'b0, halt)
      final_report();
   end
   initial begin
      #2000000;
      fails++;
      final_report();
   end
endmodule : oscillator_control_lock_bench
`default_nettype wire
